/* File: inc/lirb_defs.vh */
`ifndef LIRB_DEFS_VH
`define LIRB_DEFS_VH

// register byte addresses on the bus
`define LIRB_ADR_PEND 32'h8007EFA0
`define LIRB_ADR_ACTV 32'h8007EFA4
`define LIRB_ADR_ENAB 32'h8007EFA8
`define LIRB_ADR_ASGN 32'h8007EFAC
`define LIRB_ADR_EVST 32'h8007EFB0
`define LIRB_ADR_EVMK 32'h8007EFB4

// reset values
`define LIRB_RST_ZERO 32'h00000000
`define LIRB_RST_ASGN 32'h00000000
`define LIRB_RST_PINS 8'hFF

// writable bits of the level-assignment register (bits 0 and 16 reserved)
`define LIRB_ASGN_MASK 32'h7FFF7FFF

// field positions, lsb numbering (msb-first bit k sits at 31-k)
`define LIRB_F_EXT0 30:26
`define LIRB_F_EXT1 25:21
`define LIRB_F_EXT2 20:16
`define LIRB_F_PER0 14:10
`define LIRB_F_PER1 9:5
`define LIRB_F_TMR 4:0

// fixed levels of external pins 3..7
`define LIRB_LVL_PIN3 5'h06
`define LIRB_LVL_PIN4 5'h08
`define LIRB_LVL_PIN5 5'h0A
`define LIRB_LVL_PIN6 5'h0C
`define LIRB_LVL_PIN7 5'h0E

// level 0 is the most significant bit
`define LIRB_LVL0_BIT 32'h80000000

`endif

/* File: logic/lirb_level_map.v */
`timescale 1ns/1ps
`include "lirb_defs.vh"
module lirb_level_map (
  input wire [7:0] ext_req_i,
  input wire [1:0] periph_req_i,
  input wire periodic_timer_req_i,
  input wire [31:0] assign_i,
  output reg [31:0] pend_o
);
  // one-hot of a level, level 0 at the msb
  function [31:0] lvl_hot;
    input [4:0] lvl;
    begin
      lvl_hot = `LIRB_LVL0_BIT >> lvl;
    end
  endfunction

  // each requesting source or's in the bit of its level; no priority
  always @*
  begin
    pend_o = `LIRB_RST_ZERO;
    if (ext_req_i[0])
      pend_o = pend_o | lvl_hot(assign_i[`LIRB_F_EXT0]);
    if (ext_req_i[1])
      pend_o = pend_o | lvl_hot(assign_i[`LIRB_F_EXT1]);
    if (ext_req_i[2])
      pend_o = pend_o | lvl_hot(assign_i[`LIRB_F_EXT2]);
    if (ext_req_i[3])
      pend_o = pend_o | lvl_hot(`LIRB_LVL_PIN3);
    if (ext_req_i[4])
      pend_o = pend_o | lvl_hot(`LIRB_LVL_PIN4);
    if (ext_req_i[5])
      pend_o = pend_o | lvl_hot(`LIRB_LVL_PIN5);
    if (ext_req_i[6])
      pend_o = pend_o | lvl_hot(`LIRB_LVL_PIN6);
    if (ext_req_i[7])
      pend_o = pend_o | lvl_hot(`LIRB_LVL_PIN7);
    if (periph_req_i[0])
      pend_o = pend_o | lvl_hot(assign_i[`LIRB_F_PER0]);
    if (periph_req_i[1])
      pend_o = pend_o | lvl_hot(assign_i[`LIRB_F_PER1]);
    if (periodic_timer_req_i)
      pend_o = pend_o | lvl_hot(assign_i[`LIRB_F_TMR]);
  end
endmodule // lirb_level_map

/* File: logic/lirb_pin_sync.v */
`timescale 1ns/1ps
module lirb_pin_sync #(
  parameter W = 8,
  parameter [W-1:0] RST_VAL = {W{1'b1}}
) (
  input wire clk_i,
  input wire rst_i,
  input wire ce_i,
  input wire [W-1:0] pin_i,
  output wire [W-1:0] pin_o
);
  reg [W-1:0] s1_q;
  reg [W-1:0] s2_q;
  reg [W-1:0] s3_q;
  reg [W-1:0] out_q;
  integer i;

  // three stages; first stage feeds only the second
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
      out_q <= RST_VAL;
    end
    else if (ce_i)
    begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // a change counts once stages two and three agree, filters one glitch
      for (i = 0; i < W; i = i + 1)
        if (s2_q[i] == s3_q[i])
          out_q[i] <= s3_q[i];
    end
  end

  assign pin_o = out_q;
endmodule // lirb_pin_sync

/* File: logic/lirb_top.v */
// Behaviour
// - read-only 32-bit pending vector, level 0 at the msb.
// - enabled-active vector is pending AND enable, tracking both continuously.
// - enabled-active vector is read-only; writes to it change nothing.
// - enable vector is a 32-bit read/write register, same bit order.
// - enable bits change only by bus write or reset.
// - level-assignment register holds six independent 5-bit level fields.
// - external pins 0,1,2 fields at msb-bits 1-5, 6-10, 11-15.
// - peripheral requests 0,1 fields at msb-bits 17-21 and 22-26.
// - periodic timer field at msb-bits 27-31.
// - cpu request output high while any enabled-active bit is one.
// - external pins 3..7 drive fixed levels 6,8,10,12,14.
// - no hardware priority, no automatic mask change on entry or exit.
`timescale 1ns/1ps
`include "lirb_defs.vh"
module lirb_top (
  input wire clk_i,
  input wire rst_i,
  input wire ce_i,
  // classic wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [31:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output wire [31:0] wb_dat_o,
  output wire wb_ack_o,
  // request sources
  input wire [7:0] ext_irq_n_i,
  input wire [1:0] periph_req_i,
  input wire periodic_timer_req_i,
  // interrupt outputs
  output wire cpu_irq_o,
  output wire event_irq_o
);
  reg [31:0] pend_q;
  reg [31:0] enab_q;
  reg [31:0] asgn_q;
  reg [31:0] evst_q;
  reg [31:0] evmk_q;
  reg [31:0] rdat_q;
  reg ack_q;
  reg cpu_irq_q;
  reg [31:0] enab_d;
  reg [31:0] asgn_d;
  reg [31:0] evst_d;
  reg [31:0] evmk_d;
  reg [31:0] rdat_d;
  wire [7:0] pin_n;
  wire [7:0] ext_req;
  wire [31:0] pend_d;
  wire [31:0] actv;
  wire [31:0] rise;
  wire bus_req;
  wire wr_go;
  wire rd_go;

  // byte-lane merge, shared by every writable register
  function [31:0] lane_merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0] sel;
    integer b;
    begin
      lane_merge = old_v;
      for (b = 0; b < 4; b = b + 1)
        if (sel[b])
          lane_merge[b*8 +: 8] = new_v[b*8 +: 8];
    end
  endfunction

  // full-address compare, shared by read mux and write decode
  function hit;
    input [31:0] adr;
    input [31:0] reg_adr;
    begin
      hit = (adr == reg_adr);
    end
  endfunction

  // pins come from outside the clock domain, idle high
  lirb_pin_sync #(
    .W(8),
    .RST_VAL(`LIRB_RST_PINS)
  ) u_pin_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .pin_i(ext_irq_n_i),
    .pin_o(pin_n)
  );

  assign ext_req = ~pin_n;

  // source-to-level mapping, fixed levels for pins 3..7
  lirb_level_map u_level_map (
    .ext_req_i(ext_req),
    .periph_req_i(periph_req_i),
    .periodic_timer_req_i(periodic_timer_req_i),
    .assign_i(asgn_q),
    .pend_o(pend_d)
  );

  // bus handshake: one wait state, ack drops the cycle after it rose
  assign bus_req = wb_cyc_i & wb_stb_i;
  assign rd_go = bus_req & ~ack_q;
  // writes land on the edge that samples ack high, never earlier
  assign wr_go = bus_req & wb_we_i & ack_q;

  // derived continuously; a register would lag the pending vector
  assign actv = pend_q & enab_q;
  // new requests since last cycle feed the event status
  assign rise = pend_d & ~pend_q;

  // enable register: only bus writes touch it, no hardware path
  always @*
  begin
    enab_d = enab_q;
    if (wr_go && hit(wb_adr_i, `LIRB_ADR_ENAB))
      enab_d = lane_merge(enab_q, wb_dat_i, wb_sel_i);
  end

  // level assignment: reserved bits forced to zero
  always @*
  begin
    asgn_d = asgn_q;
    if (wr_go && hit(wb_adr_i, `LIRB_ADR_ASGN))
      asgn_d = lane_merge(asgn_q, wb_dat_i, wb_sel_i)
        & `LIRB_ASGN_MASK;
  end

  // event status: write one to clear, a new request wins over the clear
  always @*
  begin
    evst_d = evst_q;
    if (wr_go && hit(wb_adr_i, `LIRB_ADR_EVST))
      evst_d = evst_q & ~lane_merge(`LIRB_RST_ZERO, wb_dat_i, wb_sel_i);
    evst_d = evst_d | rise;
  end

  // event mask, same layout as the status
  always @*
  begin
    evmk_d = evmk_q;
    if (wr_go && hit(wb_adr_i, `LIRB_ADR_EVMK))
      evmk_d = lane_merge(evmk_q, wb_dat_i, wb_sel_i);
  end

  // read mux; unmapped addresses read zero and are still acked
  always @*
  begin
    rdat_d = `LIRB_RST_ZERO;
    if (hit(wb_adr_i, `LIRB_ADR_PEND))
      rdat_d = pend_q;
    else if (hit(wb_adr_i, `LIRB_ADR_ACTV))
      rdat_d = actv;
    else if (hit(wb_adr_i, `LIRB_ADR_ENAB))
      rdat_d = enab_q;
    else if (hit(wb_adr_i, `LIRB_ADR_ASGN))
      rdat_d = asgn_q & `LIRB_ASGN_MASK;
    else if (hit(wb_adr_i, `LIRB_ADR_EVST))
      rdat_d = evst_q;
    else if (hit(wb_adr_i, `LIRB_ADR_EVMK))
      rdat_d = evmk_q;
  end

  // state registers; clock enable freezes everything
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pend_q <= `LIRB_RST_ZERO;
      enab_q <= `LIRB_RST_ZERO;
      asgn_q <= `LIRB_RST_ASGN;
      evst_q <= `LIRB_RST_ZERO;
      evmk_q <= `LIRB_RST_ZERO;
      rdat_q <= `LIRB_RST_ZERO;
      ack_q <= 1'b0;
      cpu_irq_q <= 1'b0;
    end
    else if (ce_i)
    begin
      // no write path to the pending vector exists
      pend_q <= pend_d;
      enab_q <= enab_d;
      asgn_q <= asgn_d;
      evst_q <= evst_d;
      evmk_q <= evmk_d;
      ack_q <= rd_go;
      if (rd_go)
        rdat_q <= rdat_d;
      // or of next-cycle terms, so the output matches actv each cycle
      cpu_irq_q <= |(pend_d & enab_d);
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
  assign cpu_irq_o = cpu_irq_q;
  assign event_irq_o = |(evst_q & evmk_q);
endmodule // lirb_top

/* File: tb/lirb_assertions.sv */
`timescale 1ns/1ps
`include "lirb_defs.vh"
module lirb_chk (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [31:0] wb_adr_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire [7:0] ext_irq_n_i,
  input wire [1:0] periph_req_i,
  input wire periodic_timer_req_i,
  input wire cpu_irq_o,
  input wire event_irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // a request still waiting for its answer
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  // every source idle; pins idle high
  sequence s_quiet;
    &ext_irq_n_i && !(|periph_req_i) && !periodic_timer_req_i;
  endsequence
  sequence s_rd;
    wb_ack_o && !wb_we_i;
  endsequence
  a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_ack_follows_req: assert property (s_req |=> wb_ack_o)
    else $error("no ack one cycle after request");
  a_ack_has_cause: assert property ($rose(wb_ack_o) |-> $past(wb_stb_i))
    else $error("ack without request");
  a_rst_clears_out: assert property (disable iff (1'b0)
    rst_i |=> !cpu_irq_o && !event_irq_o && !wb_ack_o)
    else $error("outputs not cleared by reset");
  a_irq_idle_low: assert property (s_quiet [*8] |-> !cpu_irq_o)
    else $error("cpu request with no source active");
  a_pend_read_quiet: assert property (s_quiet [*8] ##0 s_rd ##0
    (wb_adr_i <= `LIRB_ADR_ACTV) |-> wb_dat_o == 32'h0)
    else $error("pending read not zero while idle");
  a_asgn_rsvd_zero: assert property (s_rd ##0
    (wb_adr_i == `LIRB_ADR_ASGN) |-> !wb_dat_o[31] && !wb_dat_o[15])
    else $error("reserved assign bits read nonzero");
  a_unmapped_zero: assert property (s_rd ##0
    (wb_adr_i[31:8] != 24'h8007EF) |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
endmodule // lirb_chk
bind lirb_top lirb_chk u_chk (.*);

/* File: tb/lirb_src_model.sv */
`timescale 1ns/1ps
module lirb_src_model (
  input wire clk_i,
  input wire [10:0] act_i,
  output reg [7:0] ext_irq_n_o = 8'hFF,
  output reg [1:0] periph_req_o = 2'h0,
  output reg periodic_timer_req_o = 1'b0
);
  // sources move just after the edge; pins are active low
  always @(posedge clk_i)
  begin
    ext_irq_n_o <= ~act_i[7:0];
    periph_req_o <= act_i[9:8];
    periodic_timer_req_o <= act_i[10];
  end
endmodule // lirb_src_model

/* File: tb/testbench.sv */
`timescale 1ns/1ps
`include "lirb_defs.vh"
module testbench;
  reg clk_i = 0, rst_i = 1, cyc = 0, we = 0;
  reg [3:0] sl = 4'hF;
  reg [31:0] adr = 0, wd = 0;
  reg [10:0] act = 0;
  wire [31:0] rd;
  wire ack, irq, evi, tmr;
  wire [7:0] pin_n;
  wire [1:0] per;
  int err_total = 0, cmp_count = 0, i;
  logic [31:0] q[$];
  logic [31:0] as, e, en;
  logic [4:0] lv[11];
  always #10 clk_i = ~clk_i;
  lirb_src_model src (.clk_i(clk_i), .act_i(act), .ext_irq_n_o(pin_n),
    .periph_req_o(per), .periodic_timer_req_o(tmr));
  lirb_top dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sl),
    .wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack), .ext_irq_n_i(pin_n),
    .periph_req_i(per), .periodic_timer_req_i(tmr), .cpu_irq_o(irq),
    .event_irq_o(evi));
  task finish_test;
    $display("errors %0d, checks %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task chk(input [31:0] g, input [31:0] x);
    cmp_count++;
    if (g !== x)
    begin
      err_total++;
      $display("Error %0t got %h exp %h", $time, g, x);
    end
  endtask
  // one classic cycle; request held until the edge that samples ack high
  task bus(input w, input [31:0] a, input [31:0] d);
    int t;
    t = 0;
    if (!w) q.push_back(d);
    @(posedge clk_i);
    cyc <= 1; we <= w; adr <= a; wd <= d;
    @(posedge clk_i);
    while (ack !== 1'b1)
    begin
      if (++t > 20)
      begin
        err_total++;
        finish_test;
      end
      @(posedge clk_i);
    end
    cyc <= 0; we <= 0;
  endtask
  // read monitor: takes read data at the edge that samples ack high
  always @(posedge clk_i)
    if (ack === 1'b1 && !we) chk(rd, q.pop_front());
  // hang guard
  initial
  begin
    #1500000 err_total++;
    finish_test;
  end
  initial
  begin
    as = $urandom(32'h3777);
    repeat (8) @(posedge clk_i);
    rst_i <= 0;
    bus(0, `LIRB_ADR_PEND, 0);
    bus(0, `LIRB_ADR_ACTV, 0);
    bus(0, `LIRB_ADR_ENAB, 0);
    bus(0, `LIRB_ADR_ASGN, 0);
    sl <= 4'h1;
    bus(1, `LIRB_ADR_ENAB, 32'hFFFFFFFF);
    sl <= 4'hF;
    bus(0, `LIRB_ADR_ENAB, 32'h000000FF);
    bus(1, `LIRB_ADR_ASGN, 32'hFFFFFFFF);
    bus(0, `LIRB_ADR_ASGN, 32'h7FFF7FFF);
    bus(1, 32'h00000100, 32'hFFFFFFFF);
    bus(0, 32'h00000100, 0);
    as = $urandom & 32'h7FFF7FFF;
    bus(1, `LIRB_ADR_ASGN, as);
    bus(1, `LIRB_ADR_EVMK, 32'hFFFFFFFF);
    // msb-first field k sits at lsb bit 31-k
    lv = '{as[30:26], as[25:21], as[20:16], 5'h06, 5'h08, 5'h0A, 5'h0C,
      5'h0E, as[14:10], as[9:5], as[4:0]};
    for (i = 0; i < 11; i++)
    begin
      e = 32'h80000000 >> lv[i];
      en = i[0] ? ~e : $urandom | e;
      act <= 11'h1 << i;
      repeat (8) @(posedge clk_i);
      bus(0, `LIRB_ADR_PEND, e);
      bus(1, `LIRB_ADR_ENAB, en);
      bus(1, `LIRB_ADR_ACTV, 32'hFFFFFFFF);
      bus(1, `LIRB_ADR_PEND, 32'h0);
      bus(0, `LIRB_ADR_ACTV, e & en);
      bus(0, `LIRB_ADR_PEND, e);
      chk({31'h0, irq}, {31'h0, |(e & en)});
      chk({31'h0, evi}, 32'h1);
      act <= 0;
      repeat (8) @(posedge clk_i);
      bus(0, `LIRB_ADR_ENAB, en);
      bus(1, `LIRB_ADR_EVST, 32'hFFFFFFFF);
      // the clear lands on the edge just passed; look once it has settled
      @(negedge clk_i);
      chk({31'h0, evi}, 32'h0);
    end
    bus(1, `LIRB_ADR_EVMK, 0);
    act <= 11'h400;
    repeat (8) @(posedge clk_i);
    chk({31'h0, evi}, 32'h0);
    bus(1, `LIRB_ADR_EVMK, 32'hFFFFFFFF);
    @(negedge clk_i);
    chk({31'h0, evi}, 32'h1);
    finish_test;
  end
endmodule // testbench
